// [logic/comm_supervision_pkg.sv]
package comm_supervision_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COMM_CONFIG = 8'h76;
  localparam logic [7:0] IDX_DBNC_LOW    = 8'h78;
  localparam logic [7:0] IDX_DBNC_HIGH   = 8'h7a;
  localparam logic [7:0] IDX_IMM_LOW     = 8'h7c;
  localparam logic [7:0] IDX_IMM_HIGH    = 8'h7e;
  localparam logic [7:0] IDX_CONTROL     = 8'h60;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'h61;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h62;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h63;
  localparam logic [7:0] IDX_STATE       = 8'h64;

  // field positions
  localparam int RETRY_LSB   = 4;
  localparam int TIMEOUT_LSB = 0;
  localparam int MODE_LSB    = 0;
  localparam int SLEEP_EN_BIT = 2;
  localparam int SCAN_LSB    = 4;

  // reset values
  localparam logic [2:0]  TIMEOUT_CODE_RESET = 3'h1;
  localparam logic [1:0]  RETRY_CODE_RESET   = 2'h0;
  localparam logic [7:0]  MASK_LOW_RESET     = 8'h20;
  localparam logic [7:0]  MASK_HIGH_RESET    = 8'h40;
  localparam logic [15:0] BAUD_DIV_RESET     = 16'h000c;

  // timeout lengths in bit times
  localparam logic [10:0] TIMEOUT_BITS_0 = 11'd276;
  localparam logic [10:0] TIMEOUT_BITS_1 = 11'd516;
  localparam logic [10:0] TIMEOUT_BITS_2 = 11'd996;
  localparam logic [10:0] TIMEOUT_BITS_3 = 11'd1956;
  localparam logic [4:0]  RETRY_BASE     = 5'd2;

  // timing
  localparam int CLK_KHZ            = 25000;
  localparam int SCAN_UNIT_MS       = 500;
  localparam int SCAN_UNIT_CYCLES   = SCAN_UNIT_MS * CLK_KHZ;

  // irq status bit positions
  localparam int ST_LINK_ERR   = 0;
  localparam int ST_ALERT_TO   = 1;
  localparam int ST_FRAME_ERR  = 2;
  localparam int ST_DBNC_ALERT = 3;
  localparam int ST_WIDTH      = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP  = 2'b01,
    MODE_SAFETY = 2'b10
  } op_mode_type;

  typedef struct packed {
    logic [1:0] retry_limit_field;
    logic [2:0] timeout_length_field;
  } comm_config_type;

  typedef struct packed {
    logic monitor_status_alert;
    logic sleep_status_alert;
    logic alert_frame_status_error;
  } alert_flags_type;

endpackage

// [logic/bit_timeout_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_timeout_timer (
  input  wire logic        aclk,        // device clock
  input  wire logic        aresetn,     // synchronous reset, low
  input  wire logic [15:0] baud_div,    // clock cycles per uart bit
  input  wire logic [2:0]  length_code, // timeout length field
  input  wire logic        txn_start,   // transaction begins
  input  wire logic        txn_done,    // transaction completes
  output logic             active,      // timeout running
  output logic             expired      // one-cycle expiry pulse
);
  import comm_supervision_pkg::*;

  logic [15:0] div_cnt;
  logic [10:0] bit_cnt;
  logic [10:0] limit;
  logic        bit_tick;

  always_comb begin
    case (length_code[1:0])
      2'b00:   limit = TIMEOUT_BITS_0;
      2'b01:   limit = TIMEOUT_BITS_1;
      2'b10:   limit = TIMEOUT_BITS_2;
      default: limit = TIMEOUT_BITS_3;
    endcase
  end

  // one enable per uart bit period
  assign bit_tick = active && (div_cnt + 16'h0001 >= baud_div);

  always_ff @(posedge aclk) begin
    if (!aresetn || txn_start || !active || bit_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active  <= 1'b0;
      bit_cnt <= 11'h000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (txn_start) begin
        active  <= !length_code[2];
        bit_cnt <= 11'h000;
      end else if (txn_done) begin
        active <= 1'b0;
      end else if (bit_tick) begin
        bit_cnt <= bit_cnt + 11'h001;
        if (bit_cnt + 11'h001 == limit) begin
          active  <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

  a_start_runs : assert property (@(posedge aclk) disable iff (!aresetn)
      txn_start && !length_code[2] |=> active)
    else $error("timer did not start on transaction");
  a_disabled_idle : assert property (@(posedge aclk) disable iff (!aresetn)
      txn_start && length_code[2] |=> !active)
    else $error("disabled timeout started");
  c_expiry : cover property (@(posedge aclk) disable iff (!aresetn) expired);

endmodule // bit_timeout_timer
`default_nettype wire

// [logic/comm_timeout_alert_mask.sv]
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - retry code 0..3 means 2,4,8,16 retries
// - timeout codes 276/516/996/1956 bits, top bit disables
// - timeout code resets to 001, 516 bits
// - timeout runs every mode, starts per transaction
// - expiry sets the link error flag
// - sleep/safety modes issue alert frames at intervals
// - expiry in sleep/safety also sets alert timeout
// - timeout counter advances once per bit period
// - debounced mask yields monitor and sleep alerts
// - immediate mask yields frame status error flag
// - both mask low bytes reset to 0x20
// - both mask high bytes reset to 0x40
// - scan code: 500 ms, 1 s, 1.5 s, reserved
module comm_timeout_alert_mask #(
  parameter int SCAN_UNIT = comm_supervision_pkg::SCAN_UNIT_CYCLES // cycles per 500 ms
) (
  input  wire logic                                   aclk,          // clock, 25 MHz
  input  wire logic                                   aresetn,       // sync reset, low
  input  wire logic [11:0]                            s_axi_awaddr,  // write address
  input  wire logic                                   s_axi_awvalid, // write address valid
  output logic                                        s_axi_awready, // write address ready
  input  wire logic [31:0]                            s_axi_wdata,   // write data
  input  wire logic [3:0]                             s_axi_wstrb,   // write strobes
  input  wire logic                                   s_axi_wvalid,  // write data valid
  output logic                                        s_axi_wready,  // write data ready
  output logic [1:0]                                  s_axi_bresp,   // write response
  output logic                                        s_axi_bvalid,  // write response valid
  input  wire logic                                   s_axi_bready,  // write response ready
  input  wire logic [11:0]                            s_axi_araddr,  // read address
  input  wire logic                                   s_axi_arvalid, // read address valid
  output logic                                        s_axi_arready, // read address ready
  output logic [31:0]                                 s_axi_rdata,   // read data
  output logic [1:0]                                  s_axi_rresp,   // read response
  output logic                                        s_axi_rvalid,  // read data valid
  input  wire logic                                   s_axi_rready,  // read data ready
  input  wire logic                                   txn_start,     // chain transaction begins
  input  wire logic                                   txn_done,      // chain transaction ends
  input  wire logic [15:0]                            status_word,   // alert buffer status bits
  input  wire logic                                   status_valid,  // status word strobe
  output comm_supervision_pkg::alert_flags_type       alert_flags,   // derived alert flags
  output logic                                        alert_frame_command, // alert frame pulse
  output logic [4:0]                                  retry_limit,   // retry count threshold
  output logic                                        irq            // interrupt, high level
);
  import comm_supervision_pkg::*;

  comm_config_type       comm_cfg;
  logic [15:0]           debounced_status_mask;
  logic [15:0]           immediate_status_mask;
  op_mode_type           mode;
  logic                  sleep_alert_en;
  logic [1:0]            monitor_scan_interval;
  logic [15:0]           baud_div;
  logic [ST_WIDTH-1:0]   irq_status;
  logic [ST_WIDTH-1:0]   irq_mask;
  logic [ST_WIDTH-1:0]   events;
  logic                  timer_active;
  logic                  timer_expired;
  logic                  prev_hit;
  logic                  wr_go;
  logic                  rd_go;
  logic [7:0]            wr_idx;
  logic [31:0]           next_rdata;
  logic                  next_rok;
  logic [31:0]           scan_cnt;
  logic [1:0]            unit_cnt;
  logic                  scan_on;
  logic                  link_error_flag;
  logic                  alert_timeout_flag;

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic masked_hit(input logic [15:0] st, input logic [15:0] msk);
    masked_hit = |(st & ~msk);
  endfunction

  // write: both address and data offered together, taken in one edge
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_idx        = reg_index(s_axi_awaddr);
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (wr_idx)
        IDX_COMM_CONFIG, IDX_DBNC_LOW, IDX_DBNC_HIGH, IDX_IMM_LOW, IDX_IMM_HIGH,
        IDX_CONTROL, IDX_BAUD_DIV, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_STATE: begin
          s_axi_bresp <= RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_cfg.timeout_length_field <= TIMEOUT_CODE_RESET;
      comm_cfg.retry_limit_field    <= RETRY_CODE_RESET;
      debounced_status_mask         <= {MASK_HIGH_RESET, MASK_LOW_RESET};
      immediate_status_mask         <= {MASK_HIGH_RESET, MASK_LOW_RESET};
      mode                          <= MODE_NORMAL;
      sleep_alert_en                <= 1'b0;
      monitor_scan_interval         <= 2'h0;
      baud_div                      <= BAUD_DIV_RESET;
      irq_mask                      <= '0;
    end else if (wr_go && s_axi_wstrb[0]) begin
      case (wr_idx)
        IDX_COMM_CONFIG: begin
          comm_cfg.retry_limit_field    <= s_axi_wdata[RETRY_LSB+:2];
          comm_cfg.timeout_length_field <= s_axi_wdata[TIMEOUT_LSB+:3];
        end
        IDX_DBNC_LOW:  debounced_status_mask[7:0]  <= s_axi_wdata[7:0];
        IDX_DBNC_HIGH: debounced_status_mask[15:8] <= s_axi_wdata[7:0];
        IDX_IMM_LOW:   immediate_status_mask[7:0]  <= s_axi_wdata[7:0];
        IDX_IMM_HIGH:  immediate_status_mask[15:8] <= s_axi_wdata[7:0];
        IDX_CONTROL: begin
          case (s_axi_wdata[MODE_LSB+:2])
            2'b01:   mode <= MODE_SLEEP;
            2'b10:   mode <= MODE_SAFETY;
            default: mode <= MODE_NORMAL;
          endcase
          sleep_alert_en        <= s_axi_wdata[SLEEP_EN_BIT];
          monitor_scan_interval <= s_axi_wdata[SCAN_LSB+:2];
        end
        IDX_BAUD_DIV: begin
          baud_div[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) begin
            baud_div[15:8] <= s_axi_wdata[15:8];
          end
        end
        IDX_IRQ_MASK: irq_mask <= s_axi_wdata[ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    case (reg_index(s_axi_araddr))
      IDX_COMM_CONFIG: next_rdata[5:0] = {comm_cfg.retry_limit_field, 1'b0,
                                          comm_cfg.timeout_length_field};
      IDX_DBNC_LOW:    next_rdata[7:0] = debounced_status_mask[7:0];
      IDX_DBNC_HIGH:   next_rdata[7:0] = debounced_status_mask[15:8];
      IDX_IMM_LOW:     next_rdata[7:0] = immediate_status_mask[7:0];
      IDX_IMM_HIGH:    next_rdata[7:0] = immediate_status_mask[15:8];
      IDX_CONTROL:     next_rdata[5:0] = {monitor_scan_interval, 1'b0, sleep_alert_en, mode};
      IDX_BAUD_DIV:    next_rdata[15:0] = baud_div;
      IDX_IRQ_STATUS:  next_rdata[ST_WIDTH-1:0] = irq_status;
      IDX_IRQ_MASK:    next_rdata[ST_WIDTH-1:0] = irq_mask;
      IDX_STATE:       next_rdata[4:0] = {timer_active, link_error_flag, alert_flags};
      default:         next_rok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  bit_timeout_timer u_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .baud_div    (baud_div),
    .length_code (comm_cfg.timeout_length_field),
    .txn_start   (txn_start),
    .txn_done    (txn_done),
    .active      (timer_active),
    .expired     (timer_expired)
  );

  assign retry_limit = RETRY_BASE << comm_cfg.retry_limit_field;

  // alert status masking, debounce needs two packets in a row
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_hit    <= 1'b0;
      alert_flags <= '0;
    end else if (status_valid) begin
      prev_hit <= masked_hit(status_word, debounced_status_mask);
      alert_flags.alert_frame_status_error <=
        masked_hit(status_word, immediate_status_mask);
      alert_flags.monitor_status_alert <= prev_hit && (mode == MODE_SAFETY) &&
        masked_hit(status_word, debounced_status_mask);
      alert_flags.sleep_status_alert <= prev_hit && (mode == MODE_SLEEP) &&
        masked_hit(status_word, debounced_status_mask);
    end
  end

  // automatic alert frames
  assign scan_on = (mode == MODE_SAFETY) || (mode == MODE_SLEEP && sleep_alert_en);

  always_ff @(posedge aclk) begin
    if (!aresetn || !scan_on || monitor_scan_interval == 2'b11) begin
      scan_cnt            <= 32'h0000_0000;
      unit_cnt            <= 2'h0;
      alert_frame_command <= 1'b0;
    end else begin
      alert_frame_command <= 1'b0;
      if (scan_cnt + 32'h0000_0001 >= 32'(SCAN_UNIT)) begin
        scan_cnt <= 32'h0000_0000;
        if (unit_cnt == monitor_scan_interval) begin
          unit_cnt            <= 2'h0;
          alert_frame_command <= 1'b1;
        end else begin
          unit_cnt <= unit_cnt + 2'h1;
        end
      end else begin
        scan_cnt <= scan_cnt + 32'h0000_0001;
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  assign events[ST_LINK_ERR]   = timer_expired;
  assign events[ST_ALERT_TO]   = timer_expired && (mode != MODE_NORMAL);
  assign events[ST_FRAME_ERR]  = status_valid && masked_hit(status_word, immediate_status_mask);
  assign events[ST_DBNC_ALERT] = status_valid && prev_hit &&
                                 masked_hit(status_word, debounced_status_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= events | (irq_status &
        ~((wr_go && s_axi_wstrb[0] && wr_idx == IDX_IRQ_STATUS) ?
          s_axi_wdata[ST_WIDTH-1:0] : '0));
    end
  end

  assign link_error_flag    = irq_status[ST_LINK_ERR];
  assign alert_timeout_flag = irq_status[ST_ALERT_TO];
  assign irq                = |(irq_status & irq_mask);

  a_timeout_reset_code : assert property (@(posedge aclk)
      $rose(aresetn) |-> comm_cfg.timeout_length_field == 3'h1)
    else $error("timeout code not 001 after reset");
  a_mask_reset_value : assert property (@(posedge aclk)
      $rose(aresetn) |-> debounced_status_mask == 16'h4020 && immediate_status_mask == 16'h4020)
    else $error("mask reset value wrong");
  a_retry_limit_value : assert property (@(posedge aclk) disable iff (!aresetn)
      comm_cfg.retry_limit_field == 2'h3 |-> retry_limit == 5'd16)
    else $error("retry limit decode wrong");
  a_expiry_link_error : assert property (@(posedge aclk) disable iff (!aresetn)
      timer_expired |=> link_error_flag)
    else $error("expiry did not set link error");
  a_expiry_alert_to : assert property (@(posedge aclk) disable iff (!aresetn)
      timer_expired && mode == MODE_SLEEP |=> alert_timeout_flag)
    else $error("sleep expiry did not set alert timeout");
  a_normal_no_alert_to : assert property (@(posedge aclk) disable iff (!aresetn)
      !alert_timeout_flag && timer_expired && mode == MODE_NORMAL
      && !$rose(alert_timeout_flag) |=> !alert_timeout_flag)
    else $error("normal mode set alert timeout");
  a_immediate_flag : assert property (@(posedge aclk) disable iff (!aresetn)
      status_valid |=> alert_flags.alert_frame_status_error ==
      |($past(status_word) & ~$past(immediate_status_mask)))
    else $error("immediate flag mismatch");
  a_frame_mode : assert property (@(posedge aclk) disable iff (!aresetn)
      alert_frame_command |-> $past(scan_on))
    else $error("alert frame outside sleep or safety mode");
  a_irq_level : assert property (@(posedge aclk) disable iff (!aresetn)
      irq_status[ST_LINK_ERR] && irq_mask[ST_LINK_ERR] |-> irq)
    else $error("irq not raised");
  a_link_err_sticky : assert property (@(posedge aclk) disable iff (!aresetn)
      link_error_flag && !(wr_go && wr_idx == IDX_IRQ_STATUS) |=> link_error_flag)
    else $error("link error flag lost without clear");
  a_reserved_no_frame : assert property (@(posedge aclk) disable iff (!aresetn)
      monitor_scan_interval == 2'b11 |=> !alert_frame_command)
    else $error("alert frame with reserved scan code");
  a_normal_no_dbnc : assert property (@(posedge aclk) disable iff (!aresetn)
      mode == MODE_NORMAL && status_valid |=>
      !alert_flags.monitor_status_alert && !alert_flags.sleep_status_alert)
    else $error("debounced alert in normal mode");
  a_reset_outputs : assert property (@(posedge aclk)
      $rose(aresetn) |-> alert_flags == '0 && !irq && !alert_frame_command &&
      retry_limit == 5'd2)
    else $error("outputs not idle after reset");
  c_frame_cmd : cover property (@(posedge aclk) disable iff (!aresetn) alert_frame_command);
  c_sleep_alert : cover property (@(posedge aclk) disable iff (!aresetn)
      alert_flags.sleep_status_alert);
  c_dbnc_alert : cover property (@(posedge aclk) disable iff (!aresetn)
      alert_flags.monitor_status_alert);
  c_alert_to : cover property (@(posedge aclk) disable iff (!aresetn) alert_timeout_flag);

endmodule // comm_timeout_alert_mask
`default_nettype wire

// [testbench/chain_model.sv]
`timescale 1ns/1ps
`default_nettype none
module chain_model (
  input  wire logic   aclk,         // device clock
  output logic        txn_start,    // transaction begins
  output logic        txn_done,     // transaction ends
  output logic [15:0] status_word,  // returned status bits
  output logic        status_valid  // status strobe
);
  initial begin
    txn_start = 1'b0;
    txn_done = 1'b0;
    status_word = 16'h0000;
    status_valid = 1'b0;
  end
  // one chain transaction; without a reply the timeout is left to run
  task automatic frame(input logic [15:0] w, input int gap, input logic done);
    @(posedge aclk);
    txn_start <= 1'b1;
    @(posedge aclk);
    txn_start <= 1'b0;
    repeat (gap) @(posedge aclk);
    if (done) begin
      txn_done <= 1'b1;
      status_valid <= 1'b1;
      status_word <= w;
      @(posedge aclk);
      txn_done <= 1'b0;
      status_valid <= 1'b0;
      status_word <= ~w;  // reply no longer held on the lines
    end
  endtask
endmodule // chain_model
`default_nettype wire

// [testbench/comm_timeout_alert_mask_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module comm_timeout_alert_mask_test;
  import comm_supervision_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, frame_cmd, irq;
  logic txn_start, txn_done, status_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, wresp;
  logic [15:0] status_word;
  logic [4:0] retry_limit;
  alert_flags_type flags;
  int miscompares, check_count, n;
  int lims[4] = '{276, 516, 996, 1956};
  int ctls[7] = '{0, 1, 5, 2, 18, 34, 50};
  int frs[7] = '{0, 0, 10, 10, 5, 4, 0};
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  comm_timeout_alert_mask #(.SCAN_UNIT(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txn_start(txn_start), .txn_done(txn_done), .status_word(status_word),
    .status_valid(status_valid), .alert_flags(flags), .alert_frame_command(frame_cmd),
    .retry_limit(retry_limit), .irq(irq));
  chain_model i_chain (.aclk(aclk), .txn_start(txn_start), .txn_done(txn_done),
    .status_word(status_word), .status_valid(status_valid));
  task automatic complete_run();
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic lost();
    miscompares++;
    complete_run();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= v;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'b111;
    for (int i = 0; i < 100 && !b; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1'b1;
        wresp = bresp;
        bready <= 1'b0;
      end
    end
    if (!b) lost();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    for (int i = 0; i < 100 && !b; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        b = 1'b1;
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    if (!b) lost();
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
    rd(idx, d, r);
    `CHK(nm, {RESP_OKAY, e}, {r, d[7:0]})
  endtask
  task automatic wait_irq(input int lo);
    i_chain.frame(16'h0000, 0, 1'b0);
    for (n = 0; n < 6000 && irq !== 1'b1; n++) @(posedge aclk);
    if (n >= 6000) lost();
    `CHK("expiry_time", 1'b1, (n >= lo - 2 && n <= lo + 6))
    wr(IDX_IRQ_STATUS, 32'h3);
    @(posedge aclk);
    `CHK("irq_cleared", 1'b0, irq)
  endtask
  task automatic frame_chk(input logic [15:0] w, input logic [2:0] e);
    i_chain.frame(w, 2, 1'b1);
    repeat (2) @(posedge aclk);
    `CHK("alert_flags", e, flags)
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd("config_reset", IDX_COMM_CONFIG, 8'h01);
    chk_rd("dbnc_low", IDX_DBNC_LOW, 8'h20);
    chk_rd("imm_low", IDX_IMM_LOW, 8'h20);
    chk_rd("dbnc_high", IDX_DBNC_HIGH, 8'h40);
    chk_rd("imm_high", IDX_IMM_HIGH, 8'h40);
    `CHK("retry_reset", 5'd2, retry_limit)
    rd(8'h00, d, r);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    wr(8'h00, 32'h0);
    `CHK("unmapped_wr", RESP_SLVERR, wresp)
    for (int k = 0; k < 4; k++) begin
      wr(IDX_COMM_CONFIG, k << RETRY_LSB);
      `CHK("retry_limit", 5'd2 << k, retry_limit)
      chk_rd("config_rw", IDX_COMM_CONFIG, k << RETRY_LSB);
    end
    wr(IDX_BAUD_DIV, 32'h1);
    `CHK("wr_okay", RESP_OKAY, wresp)
    wr(IDX_IRQ_MASK, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_COMM_CONFIG, k);
      wait_irq(lims[k]);
    end
    wr(IDX_BAUD_DIV, 32'h3);
    wr(IDX_COMM_CONFIG, 32'h0);
    wait_irq(276 * 3);
    wr(IDX_BAUD_DIV, 32'h1);
    wr(IDX_COMM_CONFIG, 32'h4);
    i_chain.frame(16'h0000, 0, 1'b0);
    repeat (2100) @(posedge aclk);
    `CHK("disabled", 1'b0, irq)
    wr(IDX_COMM_CONFIG, 32'h0);
    i_chain.frame(16'h0000, 100, 1'b1);
    repeat (400) @(posedge aclk);
    `CHK("done_in_time", 1'b0, irq)
    wr(IDX_IRQ_MASK, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(IDX_CONTROL, m);
      i_chain.frame(16'h0000, 0, 1'b0);
      repeat (300) @(posedge aclk);
      `CHK("irq_masked", 1'b0, irq)
      chk_rd("expiry_status", IDX_IRQ_STATUS, (m == 0) ? 8'h01 : 8'h03);
      wr(IDX_IRQ_STATUS, 32'hf);
    end
    for (int c = 0; c < 7; c++) begin
      wr(IDX_CONTROL, ctls[c]);
      n = 0;
      repeat (200) begin
        @(posedge aclk);
        if (frame_cmd === 1'b1) n++;
      end
      `CHK("frame_count", 1'b1, (n >= frs[c] - 2 && n <= frs[c]))
    end
    wr(IDX_CONTROL, 32'h0);
    frame_chk(16'h4020, 3'b000);
    frame_chk(16'h0001, 3'b001);
    chk_rd("frame_err_status", IDX_IRQ_STATUS, 8'h04);
    wr(IDX_IMM_LOW, 32'hff);
    wr(IDX_IMM_HIGH, 32'hff);
    frame_chk(16'hffff, 3'b000);
    wr(IDX_CONTROL, 32'h2);
    frame_chk(16'h0000, 3'b000);
    frame_chk(16'h0100, 3'b000);
    frame_chk(16'h0100, 3'b100);
    chk_rd("dbnc_status", IDX_IRQ_STATUS, 8'h0c);
    wr(IDX_CONTROL, 32'h1);
    frame_chk(16'h0000, 3'b000);
    frame_chk(16'h0002, 3'b000);
    frame_chk(16'h0002, 3'b010);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd("imm_low_rst", IDX_IMM_LOW, 8'h20);
    chk_rd("imm_high_rst", IDX_IMM_HIGH, 8'h40);
    chk_rd("config_rst", IDX_COMM_CONFIG, 8'h01);
    `CHK("flags_rst", 3'b000, flags)
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    lost();
  end
endmodule // comm_timeout_alert_mask_test
`default_nettype wire
